// file: src/mhscb_pkg.sv
package mhscb_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0]  IDX_DIAL_LINK  = 8'h09;
	localparam logic [7:0]  IDX_LINE_EVT   = 8'h0b;
	localparam logic [7:0]  IDX_ICKT_STAT  = 8'h0f;
	localparam logic [7:0]  IDX_TX_DATA    = 8'h10;
	localparam logic [7:0]  IDX_CONFIG     = 8'h12;
	localparam logic [7:0]  IDX_XFER_CTRL  = 8'h1a;
	localparam logic [7:0]  IDX_TONE_STAT  = 8'h1b;
	localparam logic [7:0]  IDX_DIAL_OUT   = 8'hd4;
	// Field positions
	localparam int          BIT_TONE_SEL   = 5;
	localparam int          BIT_RELAY_N_A       = 4;
	localparam int          BIT_OFFHOOK    = 3;
	localparam int          BIT_DISC       = 1;
	localparam int          BIT_DSR        = 4;
	localparam int          BIT_DMA_EN     = 4;
	localparam int          BIT_QUEUE_EN   = 5;
	localparam int          BIT_PAR_MODE   = 6;
	localparam int          BIT_DUAL_SEEN  = 6;
	localparam int          BIT_TONE_VALID = 4;
	localparam int          BIT_PULSE_SEL  = 6;
	localparam int          BIT_TX_EMPTY   = 0;
	// Reset values
	localparam logic [7:0]  RST_DIAL_LINK  = 8'h20;
	localparam logic [7:0]  RST_CONFIG     = 8'h00;
	localparam logic [7:0]  RST_ZERO       = 8'h00;
	// Configuration codes
	localparam logic [7:0]  CFG_DIAL       = 8'h81;
	localparam logic [7:0]  CFG_TONE_RX    = 8'h8f;
	// Timing
	localparam int          CLK_HZ         = 50_000_000;
	localparam int          PULSE_BREAK_MS = 60;
	localparam int          PULSE_MAKE_MS  = 40;
	localparam int          INTERDIGIT_MS  = 700;
	localparam int          TONE_ON_MS     = 70;
	localparam int          TONE_OFF_MS    = 70;
	localparam int          PULSE_BREAK_CYC = PULSE_BREAK_MS * (CLK_HZ / 1000);
	localparam int          PULSE_MAKE_CYC  = PULSE_MAKE_MS * (CLK_HZ / 1000);
	localparam int          INTERDIGIT_CYC  = INTERDIGIT_MS * (CLK_HZ / 1000);
	localparam int          TONE_ON_CYC     = TONE_ON_MS * (CLK_HZ / 1000);
	localparam int          TONE_OFF_CYC    = TONE_OFF_MS * (CLK_HZ / 1000);
	localparam logic [15:0] EQM_LIMIT_RST  = 16'h0800;
	localparam logic [3:0]  PULSE_TEN      = 4'h0;
	localparam logic [3:0]  TEN_PULSES     = 4'ha;

	typedef enum logic [2:0] {
		DS_IDLE  = 3'b000,
		DS_TONE  = 3'b001,
		DS_BREAK = 3'b010,
		DS_MAKE  = 3'b011,
		DS_GAP   = 3'b100
	} mhscb_dial_e;

	function automatic logic [11:0] mhscb_addr(input logic [7:0] idx);
		mhscb_addr = {2'b00, idx, 2'b00};
	endfunction : mhscb_addr

	// Keypad row/column to tone code word
	function automatic logic [3:0] mhscb_tone_code(input logic [1:0] row, input logic [1:0] col);
		logic [3:0] key;
		key = {row, col};
		case (key)
			4'h0: mhscb_tone_code = 4'h1;
			4'h1: mhscb_tone_code = 4'h2;
			4'h2: mhscb_tone_code = 4'h3;
			4'h3: mhscb_tone_code = 4'hc;
			4'h4: mhscb_tone_code = 4'h4;
			4'h5: mhscb_tone_code = 4'h5;
			4'h6: mhscb_tone_code = 4'h6;
			4'h7: mhscb_tone_code = 4'hd;
			4'h8: mhscb_tone_code = 4'h7;
			4'h9: mhscb_tone_code = 4'h8;
			4'ha: mhscb_tone_code = 4'h9;
			4'hb: mhscb_tone_code = 4'he;
			4'hc: mhscb_tone_code = 4'ha;
			4'hd: mhscb_tone_code = 4'h0;
			4'he: mhscb_tone_code = 4'hb;
			default: mhscb_tone_code = 4'hf;
		endcase
	endfunction : mhscb_tone_code
endpackage : mhscb_pkg

// file: src/mhscb_dial_seq.sv
`timescale 1ns/1ns
module mhscb_dial_seq
	import mhscb_pkg::*;
#(
	parameter int BREAK_CYC = PULSE_BREAK_CYC,
	parameter int MAKE_CYC  = PULSE_MAKE_CYC,
	parameter int GAP_CYC   = INTERDIGIT_CYC,
	parameter int TON_CYC   = TONE_ON_CYC,
	parameter int TOFF_CYC  = TONE_OFF_CYC
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       start,
	input  wire logic       tone_mode,
	input  wire logic [3:0] digit,
	output logic            busy,
	output logic            tone_on,
	output logic            line_break
);
	mhscb_dial_e  state_r,   state_nxt;
	logic [31:0]  cnt_r,     cnt_nxt;
	logic [3:0]   pulses_r,  pulses_nxt;

	always_comb begin
		state_nxt  = state_r;
		cnt_nxt    = cnt_r;
		pulses_nxt = pulses_r;
		if (cnt_r != 32'h0000_0000) begin
			cnt_nxt = cnt_r - 32'h0000_0001;
		end
		case (state_r)
			DS_IDLE: begin
				if (start && tone_mode) begin
					state_nxt = DS_TONE;
					cnt_nxt   = 32'(TON_CYC - 1);
				end else if (start) begin
					state_nxt  = DS_BREAK;
					cnt_nxt    = 32'(BREAK_CYC - 1);
					pulses_nxt = (digit == PULSE_TEN) ? TEN_PULSES : digit;
				end
			end
			DS_TONE: begin
				if (cnt_r == 32'h0000_0000) begin
					state_nxt = DS_GAP;
					cnt_nxt   = 32'(TOFF_CYC - 1);
				end
			end
			DS_BREAK: begin
				if (cnt_r == 32'h0000_0000) begin
					state_nxt  = DS_MAKE;
					cnt_nxt    = 32'(MAKE_CYC - 1);
					pulses_nxt = pulses_r - 4'h1;
				end
			end
			DS_MAKE: begin
				if (cnt_r == 32'h0000_0000 && pulses_r == 4'h0) begin
					state_nxt = DS_GAP;
					cnt_nxt   = 32'(GAP_CYC - 1);
				end else if (cnt_r == 32'h0000_0000) begin
					state_nxt = DS_BREAK;
					cnt_nxt   = 32'(BREAK_CYC - 1);
				end
			end
			DS_GAP: begin
				if (cnt_r == 32'h0000_0000) begin
					state_nxt = DS_IDLE;
				end
			end
			default: state_nxt = DS_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r  <= DS_IDLE;
			cnt_r    <= 32'h0000_0000;
			pulses_r <= 4'h0;
		end else begin
			state_r  <= state_nxt;
			cnt_r    <= cnt_nxt;
			pulses_r <= pulses_nxt;
		end
	end

	assign busy       = (state_r != DS_IDLE);
	assign tone_on    = (state_r == DS_TONE);
	assign line_break = (state_r == DS_BREAK);
endmodule : mhscb_dial_seq

// file: src/mhscb_top.sv
// Functional notes
// - Disconnect flag sets on a disconnect event in V.32 modes with eye and carrier good.
// - Disconnect flag stays set until software writes it to zero; ignore it in other modes.
// - A disconnect with carrier off or eye quality beyond the limit never sets the flag.
// - DMA enable turns the ring and data set ready outputs into tx and rx requests.
// - Tx request follows tx buffer empty, rx request follows rx buffer full, active high.
// - Requests work in parallel data mode; async rx request also needs queue enable.
// - Data set ready status bit reflects interchange circuit 107 from the core.
// - Dual-tone-seen sets in tone receiver mode when all criteria but timing hold.
// - The tone code word is written when dual-tone-seen sets.
// - Tone-valid sets only when all criteria including timing hold.
// - In dial configuration, tone dial select 1 dials tones, 0 pulses; resets to 1.
// - Tone dial select is sampled per digit so digits may mix methods.
// - Each byte written to the tx data buffer in dial mode is one digit to dial, except bytes above 9 when pulse dialing, which are dropped.
// - Pulse dialing goes to the off-hook relay when select is 0, the relay_n_a relay when 1.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ns
module mhscb_top
	import mhscb_pkg::*;
#(
	parameter int          BREAK_CYC = PULSE_BREAK_CYC,
	parameter int          MAKE_CYC  = PULSE_MAKE_CYC,
	parameter int          GAP_CYC   = INTERDIGIT_CYC,
	parameter int          TON_CYC   = TONE_ON_CYC,
	parameter int          TOFF_CYC  = TONE_OFF_CYC,
	parameter logic [15:0] EQM_LIMIT = EQM_LIMIT_RST
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        link_mode_v32,
	input  wire logic        link_mode_async,
	input  wire logic        line_disconnect_event,
	input  wire logic [15:0] eye_quality_metric,
	input  wire logic        carrier_detect_flag,
	input  wire logic        ring_detect,
	input  wire logic        circuit_107,
	input  wire logic        rx_buffer_full_flag,
	input  wire logic        core_tx_take,
	input  wire logic        tone_present,
	input  wire logic        tone_timing_ok,
	input  wire logic [1:0]  tone_row,
	input  wire logic [1:0]  tone_col,
	output logic             ring_indicator_n,
	output logic             data_set_ready_n,
	output logic [7:0]       core_tx_data,
	output logic             offhook_relay_n,
	output logic             relay_n_a,
	output logic             dial_tone_on,
	output logic [3:0]       dial_tone_code
);
	// Registered state
	logic [7:0]  dial_link_r,   dial_link_nxt;
	logic [7:0]  config_r,      config_nxt;
	logic [7:0]  xfer_ctrl_r,   xfer_ctrl_nxt;
	logic        pulse_sel_r,   pulse_sel_nxt;
	logic        disc_r,        disc_nxt;
	logic        dual_seen_r,   dual_seen_nxt;
	logic        tone_valid_r,  tone_valid_nxt;
	logic [3:0]  tone_code_r,   tone_code_nxt;
	logic [7:0]  tx_data_r,     tx_data_nxt;
	logic        tx_full_r,     tx_full_nxt;

	// Next values of output flops
	logic [31:0] prdata_nxt;
	logic        pready_nxt;
	logic        pslverr_nxt;
	logic        ri_n_nxt;
	logic        dsr_n_nxt;
	logic        offhook_n_nxt;
	logic        relay_n_a_n_nxt;
	logic [3:0]  tone_code_out_nxt;

	// Strobes and qualifiers
	logic        start_dial;
	logic        start_tone;
	logic        seq_busy;
	logic        seq_tone_on;
	logic        seq_break;
	logic        wr_en;
	logic        setup;
	logic        dial_mode;
	logic        tone_rx_mode;
	logic        tx_empty;
	logic        tx_req;
	logic        rx_req;
	logic        disc_set;
	logic        tone_seen_now;
	logic        tx_wr;

	assign setup        = psel && !penable;
	assign wr_en        = psel && penable && pwrite && pready;
	assign tx_wr        = wr_en && (paddr == mhscb_addr(IDX_TX_DATA));
	assign dial_mode    = (config_r == CFG_DIAL);
	assign tone_rx_mode = (config_r == CFG_TONE_RX);
	assign tx_empty     = !tx_full_r;

	// Disconnect detection qualifiers
	assign disc_set = line_disconnect_event && link_mode_v32 && carrier_detect_flag
		&& (eye_quality_metric < EQM_LIMIT);

	// DMA requests
	assign tx_req = tx_empty && xfer_ctrl_r[BIT_PAR_MODE];
	assign rx_req = rx_buffer_full_flag && xfer_ctrl_r[BIT_PAR_MODE]
		&& (!link_mode_async || xfer_ctrl_r[BIT_QUEUE_EN]);

	assign tone_seen_now = tone_rx_mode && tone_present;

	// Digit launch: select bit sampled when each digit starts
	assign start_dial = dial_mode && tx_full_r && !seq_busy;
	assign start_tone = dial_link_r[BIT_TONE_SEL];

	mhscb_dial_seq #(
		.BREAK_CYC (BREAK_CYC),
		.MAKE_CYC  (MAKE_CYC),
		.GAP_CYC   (GAP_CYC),
		.TON_CYC   (TON_CYC),
		.TOFF_CYC  (TOFF_CYC)
	) u_dial_seq (
		.pclk       (pclk),
		.presetn    (presetn),
		.start      (start_dial && (start_tone || tx_data_r <= 8'h09)),
		.tone_mode  (start_tone),
		.digit      (tx_data_r[3:0]),
		.busy       (seq_busy),
		.tone_on    (seq_tone_on),
		.line_break (seq_break)
	);

	// Register bank next state
	always_comb begin
		dial_link_nxt  = dial_link_r;
		config_nxt     = config_r;
		xfer_ctrl_nxt  = xfer_ctrl_r;
		pulse_sel_nxt  = pulse_sel_r;
		disc_nxt       = disc_r;
		tx_data_nxt    = tx_data_r;
		tx_full_nxt    = tx_full_r;
		if (wr_en) begin
			// Reserved bits are masked off on write
			case (paddr)
				mhscb_addr(IDX_DIAL_LINK): begin
					dial_link_nxt = pwdata[7:0] & 8'h38;
				end
				mhscb_addr(IDX_LINE_EVT): begin
					if (!pwdata[BIT_DISC]) begin
						disc_nxt = 1'b0;
					end
				end
				mhscb_addr(IDX_TX_DATA): begin
					tx_data_nxt = pwdata[7:0];
					tx_full_nxt = 1'b1;
				end
				mhscb_addr(IDX_CONFIG): begin
					config_nxt = pwdata[7:0];
				end
				mhscb_addr(IDX_XFER_CTRL): begin
					xfer_ctrl_nxt = pwdata[7:0] & 8'h70;
				end
				mhscb_addr(IDX_DIAL_OUT): begin
					pulse_sel_nxt = pwdata[BIT_PULSE_SEL];
				end
				default: begin
				end
			endcase
		end
		// Set wins over a same-cycle clear
		if (disc_set) begin
			disc_nxt = 1'b1;
		end
		// Buffer drained by dialer or core; a same-cycle host write keeps it full
		if ((start_dial || (!dial_mode && core_tx_take)) && !tx_wr) begin
			tx_full_nxt = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dial_link_r <= RST_DIAL_LINK;
			config_r    <= RST_CONFIG;
			xfer_ctrl_r <= RST_ZERO;
			pulse_sel_r <= 1'b0;
			disc_r      <= 1'b0;
			tx_data_r   <= RST_ZERO;
			tx_full_r   <= 1'b0;
		end else begin
			dial_link_r <= dial_link_nxt;
			config_r    <= config_nxt;
			xfer_ctrl_r <= xfer_ctrl_nxt;
			pulse_sel_r <= pulse_sel_nxt;
			disc_r      <= disc_nxt;
			tx_data_r   <= tx_data_nxt;
			tx_full_r   <= tx_full_nxt;
		end
	end

	// Tone receiver status
	always_comb begin
		dual_seen_nxt  = tone_seen_now;
		tone_valid_nxt = tone_seen_now && tone_timing_ok;
		tone_code_nxt  = tone_code_r;
		// Code latched only as the seen flag rises
		if (tone_seen_now && !dual_seen_r) begin
			tone_code_nxt = mhscb_tone_code(tone_row, tone_col);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dual_seen_r  <= 1'b0;
			tone_valid_r <= 1'b0;
			tone_code_r  <= 4'h0;
		end else begin
			dual_seen_r  <= dual_seen_nxt;
			tone_valid_r <= tone_valid_nxt;
			tone_code_r  <= tone_code_nxt;
		end
	end

	// APB read data and error, captured in the setup phase
	always_comb begin
		prdata_nxt  = prdata;
		pslverr_nxt = pslverr;
		// Zero wait states once out of reset
		pready_nxt  = 1'b1;
		if (setup) begin
			prdata_nxt  = 32'h0000_0000;
			pslverr_nxt = 1'b0;
			case (paddr)
				mhscb_addr(IDX_DIAL_LINK): prdata_nxt[7:0] = dial_link_r;
				mhscb_addr(IDX_LINE_EVT):  prdata_nxt[BIT_DISC] = disc_r;
				mhscb_addr(IDX_ICKT_STAT): prdata_nxt[BIT_DSR] = circuit_107;
				mhscb_addr(IDX_TX_DATA):   prdata_nxt[BIT_TX_EMPTY] = tx_empty;
				mhscb_addr(IDX_CONFIG):    prdata_nxt[7:0] = config_r;
				mhscb_addr(IDX_XFER_CTRL): prdata_nxt[7:0] = xfer_ctrl_r;
				mhscb_addr(IDX_TONE_STAT): begin
					prdata_nxt[BIT_DUAL_SEEN]  = dual_seen_r;
					prdata_nxt[BIT_TONE_VALID] = tone_valid_r;
					prdata_nxt[3:0]            = tone_code_r;
				end
				mhscb_addr(IDX_DIAL_OUT):  prdata_nxt[BIT_PULSE_SEL] = pulse_sel_r;
				default:                   pslverr_nxt = 1'b1;
			endcase
		end
	end

	// Pin outputs
	always_comb begin
		ri_n_nxt  = !ring_detect;
		dsr_n_nxt = !circuit_107;
		// DMA remap of ring and data set ready
		if (xfer_ctrl_r[BIT_DMA_EN]) begin
			ri_n_nxt  = tx_req;
			dsr_n_nxt = rx_req;
		end
		// Pulse breaks on the selected relay
		offhook_n_nxt = !dial_link_r[BIT_OFFHOOK];
		relay_n_a_n_nxt    = !dial_link_r[BIT_RELAY_N_A];
		if (dial_mode && seq_break && !pulse_sel_r) begin
			offhook_n_nxt = 1'b1;
		end
		if (dial_mode && seq_break && pulse_sel_r) begin
			relay_n_a_n_nxt = 1'b1;
		end
		// Tone burst code taken at digit launch
		tone_code_out_nxt = dial_tone_code;
		if (start_dial && start_tone) begin
			tone_code_out_nxt = tx_data_r[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata           <= 32'h0000_0000;
			pslverr          <= 1'b0;
			pready           <= 1'b0;
			ring_indicator_n <= 1'b1;
			data_set_ready_n <= 1'b1;
			core_tx_data     <= 8'h00;
			offhook_relay_n  <= 1'b1;
			relay_n_a        <= 1'b1;
			dial_tone_on     <= 1'b0;
			dial_tone_code   <= 4'h0;
		end else begin
			prdata           <= prdata_nxt;
			pslverr          <= pslverr_nxt;
			pready           <= pready_nxt;
			ring_indicator_n <= ri_n_nxt;
			data_set_ready_n <= dsr_n_nxt;
			core_tx_data     <= tx_data_nxt;
			offhook_relay_n  <= offhook_n_nxt;
			relay_n_a        <= relay_n_a_n_nxt;
			dial_tone_on     <= seq_tone_on;
			dial_tone_code   <= tone_code_out_nxt;
		end
	end
endmodule : mhscb_top

// file: bench/mhscb_monitor.sv
`timescale 1ns/1ns
module mhscb_monitor #(
	parameter int TON_CYC = 8
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        link_mode_async,
	input wire logic        ring_detect,
	input wire logic        circuit_107,
	input wire logic        rx_buffer_full_flag,
	input wire logic        ring_indicator_n,
	input wire logic        data_set_ready_n,
	input wire logic        dial_tone_on,
	input wire logic [3:0]  dial_tone_code
);
	logic       dma_r, par_r, que_r, dma_nxt, par_nxt, que_nxt;
	logic       wr_xfer, mapped, exp_dsr;
	logic [7:0] cnt_r, cnt_nxt;
	assign wr_xfer = psel && penable && pwrite && pready && paddr == 12'h068;
	assign mapped = paddr inside {12'h024, 12'h02c, 12'h03c, 12'h040, 12'h048, 12'h068,
		12'h06c, 12'h350};
	assign exp_dsr = dma_r ? (rx_buffer_full_flag && par_r && (!link_mode_async || que_r))
		: !circuit_107;
	always_comb begin
		{dma_nxt, par_nxt, que_nxt} = wr_xfer ? {pwdata[4], pwdata[6], pwdata[5]}
			: {dma_r, par_r, que_r};
		cnt_nxt = dial_tone_on ? cnt_r + 8'h01 : 8'h00;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{dma_r, par_r, que_r} <= 3'b000;
			cnt_r <= 8'h00;
		end else begin
			{dma_r, par_r, que_r} <= {dma_nxt, par_nxt, que_nxt};
			cnt_r <= cnt_nxt;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_held: assert property ($past(presetn, 2) |-> pready)
		else $error("pready low after reset");
	a_unmapped_err: assert property (psel && penable |-> pslverr == !mapped)
		else $error("pslverr does not match address map");
	a_unmapped_zero: assert property (psel && penable && !mapped |-> prdata == 32'h0000_0000)
		else $error("unmapped read data not zero");
	a_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h00_0000)
		else $error("unused read bits not zero");
	a_ring_plain: assert property ($past(presetn) && !$past(dma_r) |->
		ring_indicator_n == !$past(ring_detect)) else $error("ring output wrong");
	a_dsr_follow: assert property ($past(presetn) |->
		data_set_ready_n == $past(exp_dsr)) else $error("dsr output wrong");
	a_tone_len: assert property ($fell(dial_tone_on) |-> cnt_r == TON_CYC)
		else $error("tone burst length wrong");
	a_code_steady: assert property (dial_tone_on && $past(dial_tone_on) |->
		$stable(dial_tone_code)) else $error("tone code changed in burst");
endmodule : mhscb_monitor

// file: bench/mhscb_host.sv
`timescale 1ns/1ns
module mhscb_host (
	input wire logic        pclk,
	output logic            psel,
	output logic            penable,
	output logic            pwrite,
	output logic [11:0]     paddr,
	output logic [31:0]     pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	initial begin
		{psel, penable, pwrite} = 3'b000;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err, output logic hung);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		hung = 1'b1;
		for (n = 0; n < 20 && hung; n++) begin
			@(posedge pclk);
			hung = !pready;
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : mhscb_host

// file: bench/mhscb_bench.sv
`timescale 1ns/1ns
module mhscb_bench;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, e, h;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic        link_mode_v32 = 1'b0, link_mode_async = 1'b0, line_disconnect_event = 1'b0;
	logic [15:0] eye_quality_metric = 16'h0000;
	logic        carrier_detect_flag = 1'b0, ring_detect = 1'b1, circuit_107 = 1'b1;
	logic        rx_buffer_full_flag = 1'b0, core_tx_take = 1'b0;
	logic        tone_present = 1'b0, tone_timing_ok = 1'b0;
	logic [1:0]  tone_row = 2'h0, tone_col = 2'h0;
	logic        ring_indicator_n, data_set_ready_n, offhook_relay_n, relay_n_a, dial_tone_on;
	logic [7:0]  core_tx_data;
	logic [3:0]  dial_tone_code;
	int          bad_count = 0, total_checks = 0, oh, ta, tn;
	localparam logic [63:0] KEY_CODES = 64'hfb0a_e987_d654_c321;
	always #10 pclk = ~pclk;
	mhscb_top #(.BREAK_CYC(4), .MAKE_CYC(4), .GAP_CYC(10), .TON_CYC(8), .TOFF_CYC(6)) DUT (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .link_mode_v32, .link_mode_async, .line_disconnect_event,
		.eye_quality_metric, .carrier_detect_flag, .ring_detect, .circuit_107,
		.rx_buffer_full_flag, .core_tx_take, .tone_present, .tone_timing_ok, .tone_row,
		.tone_col, .ring_indicator_n, .data_set_ready_n, .core_tx_data, .offhook_relay_n,
		.relay_n_a, .dial_tone_on, .dial_tone_code);
	mhscb_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr);
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic w = 1'b1);
		host.xfer(w, a, d, q, e, h);
		if (h) begin
			bad_count++;
			summarize();
		end
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
		wr(a, 32'h0000_0000, 1'b0);
		chk(q, exp);
		chk({31'h0, e}, {31'h0, experr});
	endtask : rd
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : wait_cyc
	task automatic disc(input logic c, input logic [15:0] m);
		carrier_detect_flag <= c;
		eye_quality_metric <= m;
		@(posedge pclk);
		line_disconnect_event <= 1'b1;
		@(posedge pclk);
		line_disconnect_event <= 1'b0;
		wait_cyc(3);
	endtask : disc
	task automatic watch(input int n);
		logic [2:0] prev;
		{oh, ta, tn} = {32'h0, 32'h0, 32'h0};
		prev = {offhook_relay_n, relay_n_a, dial_tone_on};
		repeat (n) begin
			@(posedge pclk);
			oh += int'(offhook_relay_n && !prev[2]);
			ta += int'(relay_n_a && !prev[1]);
			tn += int'(dial_tone_on && !prev[0]);
			prev = {offhook_relay_n, relay_n_a, dial_tone_on};
		end
	endtask : watch
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		summarize();
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		link_mode_v32 <= 1'b1;
		wait_cyc(2);
		rd(12'h024, 32'h0000_0020, 1'b0);
		rd(12'h02c, 32'h0000_0000, 1'b0);
		rd(12'h004, 32'h0000_0000, 1'b1);
		disc(1'b1, 16'h0100);
		rd(12'h02c, 32'h0000_0002, 1'b0);
		wr(12'h02c, 32'h0000_0002);
		rd(12'h02c, 32'h0000_0002, 1'b0);
		wr(12'h02c, 32'h0000_0000);
		rd(12'h02c, 32'h0000_0000, 1'b0);
		disc(1'b0, 16'h0100);
		rd(12'h02c, 32'h0000_0000, 1'b0);
		disc(1'b1, 16'h0800);
		rd(12'h02c, 32'h0000_0000, 1'b0);
		link_mode_v32 <= 1'b0;
		disc(1'b1, 16'h0100);
		rd(12'h02c, 32'h0000_0000, 1'b0);
		chk({30'h0, ring_indicator_n, data_set_ready_n}, 32'h0000_0000);
		rd(12'h03c, 32'h0000_0010, 1'b0);
		circuit_107 <= 1'b0;
		ring_detect <= 1'b0;
		rd(12'h03c, 32'h0000_0000, 1'b0);
		chk({30'h0, ring_indicator_n, data_set_ready_n}, 32'h0000_0003);
		circuit_107 <= 1'b1;
		ring_detect <= 1'b1;
		wr(12'h068, 32'h0000_0050);
		wait_cyc(2);
		chk({30'h0, ring_indicator_n, data_set_ready_n}, 32'h0000_0002);
		rx_buffer_full_flag <= 1'b1;
		wr(12'h040, 32'h0000_0055);
		wait_cyc(2);
		chk({22'h0, core_tx_data, ring_indicator_n, data_set_ready_n}, 32'h0000_0155);
		core_tx_take <= 1'b1;
		@(posedge pclk);
		core_tx_take <= 1'b0;
		link_mode_async <= 1'b1;
		wait_cyc(2);
		chk({30'h0, ring_indicator_n, data_set_ready_n}, 32'h0000_0002);
		wr(12'h068, 32'h0000_0070);
		wait_cyc(2);
		chk({30'h0, ring_indicator_n, data_set_ready_n}, 32'h0000_0003);
		wr(12'h068, 32'h0000_0000);
		tone_present <= 1'b1;
		wait_cyc(3);
		rd(12'h06c, 32'h0000_0000, 1'b0);
		tone_present <= 1'b0;
		wr(12'h048, 32'h0000_008f);
		for (int k = 0; k < 16; k++) begin
			{tone_row, tone_col} <= k[3:0];
			tone_present <= 1'b1;
			wait_cyc(3);
			rd(12'h06c, {24'h00_0000, 4'h4, KEY_CODES[k*4 +: 4]}, 1'b0);
			tone_timing_ok <= 1'b1;
			wait_cyc(3);
			rd(12'h06c, {24'h00_0000, 4'h5, KEY_CODES[k*4 +: 4]}, 1'b0);
			tone_present <= 1'b0;
			tone_timing_ok <= 1'b0;
			wait_cyc(3);
		end
		wr(12'h048, 32'h0000_0081);
		wr(12'h040, 32'h0000_0007);
		for (int n = 0; n < 30 && dial_tone_on !== 1'b1; n++) begin
			@(posedge pclk);
		end
		if (dial_tone_on !== 1'b1) begin
			bad_count++;
			summarize();
		end
		chk({27'h0, dial_tone_on, dial_tone_code}, 32'h0000_0017);
		wr(12'h024, 32'h0000_0008);
		wr(12'h040, 32'h0000_0003);
		watch(120);
		chk({8'h0, oh[7:0], ta[7:0], tn[7:0]}, 32'h0003_0000);
		wr(12'h350, 32'h0000_0040);
		wr(12'h024, 32'h0000_0018);
		wr(12'h040, 32'h0000_0000);
		watch(200);
		chk({8'h0, oh[7:0], ta[7:0], tn[7:0]}, 32'h0000_0a00);
		summarize();
	end
endmodule : mhscb_bench
bind mhscb_top mhscb_monitor #(.TON_CYC(TON_CYC)) u_mon (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link_mode_async, .ring_detect,
	.circuit_107, .rx_buffer_full_flag, .ring_indicator_n, .data_set_ready_n, .dial_tone_on,
	.dial_tone_code);
